// >>> rtl/adc_serial_cmd.sv
// serial command decoder and configuration register bank of the converter
// assumes conversion data and status come from logic on mclk_in
`timescale 1ns/100ps
module adc_serial_cmd (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // serial link
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  // converter side
  input wire logic [7:0] status_in,
  input wire logic [23:0] conv_data_in,
  input wire logic clock_source_pin_in,
  input wire logic [7:0] port_pins_in,
  output logic convert_out,
  output logic dev_reset_out,
  // configuration
  output logic serial_timeout_select_out,
  output logic scan_or_single_select_out,
  output logic external_path_select_out,
  output logic clock_out_enable_out,
  output logic chop_enable_out,
  output logic low_power_select_out,
  output logic [adc_cmd_pkg::DLY_W-1:0] settle_delay_out,
  output logic [adc_cmd_pkg::BIAS_W-1:0] sensor_bias_level_out,
  output logic [adc_cmd_pkg::RATE_W-1:0] conversion_rate_select_out,
  // channel selections in force
  output logic [7:0] fixed_input_out,
  output logic [7:0] diff_scan_out,
  output logic [15:0] single_scan_out,
  output logic [7:0] monitor_scan_out,
  // port
  output logic [7:0] port_direction_out,
  output logic [7:0] port_value_out
);
  import adc_cmd_pkg::*;

  typedef struct packed {
    cmd_state_t st;
    logic [3:0] addr;
    logic burst;
    logic [1:0] idx;
    logic [7:0] tx;
    logic [7:0] snap_stat;
    logic [23:0] snap_data;
    logic [8:0][7:0] regs;
    logic cs_s1;
    logic cs_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic csel_s1;
    logic csel_s2;
    logic [11:0] tmo;
    logic [1:0] hold;
    logic link_rst;
    logic convert;
    logic dev_reset;
    logic clk_en;
    logic [7:0] fix_act;
    logic [7:0] diff_act;
    logic [15:0] sg_act;
    logic [7:0] mon_act;
  } state_t;

  state_t q;
  state_t n;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic link_rst_any;
  logic [2:0] cmd_code;
  logic burst_bit;
  logic [3:0] addr_bits;
  logic byte_ev;
  logic take;
  logic sck_idle;
  logic [11:0] tmo_last;
  logic tmo_fire;
  logic dstat;

  //////////////////////////////////////////////////////////////////////
  // reply byte of a data read; idx counts bytes from the first
  function automatic logic [7:0] data_byte(input logic [7:0] s,
    input logic [23:0] d, input logic [1:0] idx, input logic with_stat);
    logic [1:0] k;
    k = with_stat ? idx : idx + 2'h1;
    if (!with_stat && idx == LAST_DATA_IDX)
      return 8'h00;
    unique case (k)
      2'h0: return s;
      2'h1: return d[23:16];
      2'h2: return d[15:8];
      2'h3: return d[7:0];
    endcase
  endfunction

  // port value reads the pins, not the output latch
  function automatic logic [7:0] reg_read(input state_t s,
    input logic [3:0] a);
    if (a == ADDR_ID)
      return PART_ID_VALUE;
    else if (a == ADDR_PVAL)
      return s.pin_s2;
    else if (a < ADDR_ID)
      return s.regs[a];
    else
      return 8'h00;
  endfunction

  function automatic state_t reset_state();
    state_t s;
    s = '0;
    s.st = ST_CMD;
    s.regs = REG_RESET;
    s.cs_s1 = 1'b1;
    s.cs_s2 = 1'b1;
    s.hold = HOLD_CYC;
    return s;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // link shifter; cs high or a timeout clears it while its clock stands
  assign link_rst_any = cs_n_in | q.link_rst;

  adc_serial_link u_link (
    .sclk_in(sclk_in),
    .link_rst_in(link_rst_any),
    .mosi_in(mosi_in),
    .miso_out(miso_out),
    .tx_byte_in(q.tx),
    .rx_byte_out(rx_byte),
    .rx_toggle_out(rx_tgl)
  );

  // command byte fields and link events
  assign cmd_code = rx_byte[CMD_MSB:CMD_LSB];
  assign burst_bit = rx_byte[BURST_BIT];
  assign addr_bits = rx_byte[ADDR_MSB:ADDR_LSB];
  // a reset of the shifter flips the toggle too, hence the hold mask
  assign byte_ev = (q.tg_s2 != q.tg_s3) && (q.hold == 2'h0) && !q.cs_s2;
  assign sck_idle = q.sck_s2 == q.sck_s3;
  assign tmo_last = q.regs[ADDR_CFG_A][A_TMO_BIT] ? TMO_SHORT_LAST
    : TMO_LONG_LAST;
  assign tmo_fire = !q.cs_s2 && sck_idle && q.tmo >= tmo_last;
  assign take = byte_ev && !tmo_fire;
  // status in a direct read only in auto-scan with the status bit set
  assign dstat = !q.regs[ADDR_CFG_A][A_SCAN_BIT]
    && q.regs[ADDR_CFG_A][A_STAT_BIT];

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    n = q;
    n.convert = 1'b0;
    n.dev_reset = 1'b0;
    n.link_rst = 1'b0;
    // synchronisers for pins and the link toggle
    n.cs_s1 = cs_n_in;
    n.cs_s2 = q.cs_s1;
    n.sck_s1 = sclk_in;
    n.sck_s2 = q.sck_s1;
    n.sck_s3 = q.sck_s2;
    n.tg_s1 = rx_tgl;
    n.tg_s2 = q.tg_s1;
    n.tg_s3 = q.tg_s2;
    n.pin_s1 = port_pins_in;
    n.pin_s2 = q.pin_s1;
    n.csel_s1 = clock_source_pin_in;
    n.csel_s2 = q.csel_s1;
    // inactivity counter runs only inside a frame
    if (q.cs_s2 || !sck_idle || tmo_fire)
      n.tmo = '0;
    else
      n.tmo = q.tmo + 12'h001;
    if (q.cs_s2 || tmo_fire)
      n.hold = HOLD_CYC;
    else if (q.hold != 2'h0)
      n.hold = q.hold - 2'h1;
    // frame end or timeout wins over any byte in the same cycle
    if (q.cs_s2 || tmo_fire)
    begin
      n.st = ST_CMD;
      n.link_rst = tmo_fire;
      n.snap_stat = status_in;
      n.snap_data = conv_data_in;
      n.tx = data_byte(status_in, conv_data_in, 2'h0, dstat);
    end
    else if (take)
    begin
      unique case (q.st)
        ST_CMD:
        begin
          unique case (cmd_code)
            CMD_DIRECT_A, CMD_DIRECT_B:
            begin
              // the command slot already carried the first byte
              n.st = ST_DIRECT;
              n.idx = 2'h1;
              n.tx = data_byte(q.snap_stat, q.snap_data, 2'h1, dstat);
            end
            CMD_FRAMED:
            begin
              n.st = ST_FRAMED;
              n.idx = 2'h0;
              n.tx = q.snap_stat;
            end
            CMD_RREG:
            begin
              n.st = ST_RREG;
              n.addr = addr_bits;
              n.burst = burst_bit;
              n.tx = reg_read(q, addr_bits);
            end
            CMD_WREG:
            begin
              n.st = ST_WREG;
              n.addr = addr_bits;
              n.burst = burst_bit;
              n.tx = 8'h00;
            end
            CMD_PULSE:
              n.convert = 1'b1;
            CMD_RSVD:
              n.convert = 1'b0;
            CMD_RESET:
            begin
              n.dev_reset = 1'b1;
              n.regs = REG_RESET;
            end
          endcase
        end
        ST_DIRECT:
        begin
          // past the last byte only zeros go out until a reset
          if (q.idx != LAST_DATA_IDX)
          begin
            n.idx = q.idx + 2'h1;
            n.tx = data_byte(q.snap_stat, q.snap_data, n.idx, dstat);
          end
          else
            n.tx = 8'h00;
        end
        ST_FRAMED:
        begin
          if (q.idx == LAST_DATA_IDX)
          begin
            n.st = ST_CMD;
            n.tx = data_byte(q.snap_stat, q.snap_data, 2'h0, dstat);
          end
          else
          begin
            n.idx = q.idx + 2'h1;
            n.tx = data_byte(q.snap_stat, q.snap_data, n.idx, 1'b1);
          end
        end
        ST_RREG, ST_WREG:
        begin
          if (q.st == ST_WREG && q.addr < ADDR_ID)
            n.regs[q.addr] = rx_byte & REG_WMASK[q.addr];
          if (q.burst && q.addr < ADDR_ID)
          begin
            n.addr = q.addr + 4'h1;
            n.tx = (q.st == ST_RREG) ? reg_read(q, n.addr) : 8'h00;
          end
          else
          begin
            n.st = ST_CMD;
            n.tx = data_byte(q.snap_stat, q.snap_data, 2'h0, dstat);
          end
        end
      endcase
    end
    // selections in force; one cycle behind the registers
    n.clk_en = q.regs[ADDR_CFG_A][A_CLKEN_BIT] && !q.csel_s2;
    if (q.regs[ADDR_CFG_A][A_SCAN_BIT])
    begin
      n.fix_act = q.regs[ADDR_FIXED];
      n.diff_act = 8'h00;
      n.sg_act = 16'h0000;
      n.mon_act = 8'h00;
    end
    else
    begin
      n.fix_act = 8'h00;
      n.diff_act = q.regs[ADDR_DIFF];
      n.sg_act = {q.regs[ADDR_SG_HI], q.regs[ADDR_SG_LO]};
      n.mon_act = q.regs[ADDR_MON];
    end
    if (!rstn_in)
    begin
      n = reset_state();
      // the clock pin keeps tracking through reset, so no false enable
      n.csel_s1 = clock_source_pin_in;
      n.csel_s2 = q.csel_s1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    q <= n;
  end

  //////////////////////////////////////////////////////////////////////
  // outputs, all straight from state flops
  assign convert_out = q.convert;
  assign dev_reset_out = q.dev_reset;
  assign serial_timeout_select_out = q.regs[ADDR_CFG_A][A_TMO_BIT];
  assign scan_or_single_select_out = q.regs[ADDR_CFG_A][A_SCAN_BIT];
  // monitor readings keep the internal path whatever this says
  assign external_path_select_out = q.regs[ADDR_CFG_A][A_EXT_BIT];
  assign clock_out_enable_out = q.clk_en;
  assign chop_enable_out = q.regs[ADDR_CFG_A][A_CHOP_BIT];
  assign low_power_select_out = q.regs[ADDR_CFG_B][B_IDLE_BIT];
  assign settle_delay_out =
    q.regs[ADDR_CFG_B][B_DLY_MSB:B_DLY_LSB];
  assign sensor_bias_level_out =
    q.regs[ADDR_CFG_B][B_BIAS_MSB:B_BIAS_LSB];
  assign conversion_rate_select_out =
    q.regs[ADDR_CFG_B][B_RATE_MSB:B_RATE_LSB];
  assign fixed_input_out = q.fix_act;
  assign diff_scan_out = q.diff_act;
  assign single_scan_out = q.sg_act;
  assign monitor_scan_out = q.mon_act;
  assign port_direction_out = q.regs[ADDR_PDIR];
  assign port_value_out = q.regs[ADDR_PVAL];

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  direct_start_a: assert property (take && q.st == ST_CMD
    && (cmd_code == CMD_DIRECT_A || cmd_code == CMD_DIRECT_B)
    |=> q.st == ST_DIRECT ##1 q.st == ST_DIRECT || q.cs_s2
    || $past(tmo_fire))
    else $error("direct read not entered or not held");
  framed_start_a: assert property (take && q.st == ST_CMD
    && cmd_code == CMD_FRAMED
    |=> q.st == ST_FRAMED && q.tx == $past(q.snap_stat))
    else $error("framed read does not start with status");
  reg_read_a: assert property (take && q.st == ST_CMD
    && cmd_code == CMD_RREG
    |=> q.st == ST_RREG && q.addr == $past(addr_bits)
    && q.tx == reg_read(q, q.addr))
    else $error("register read start wrong");
  pulse_conv_a: assert property (take && q.st == ST_CMD
    && cmd_code == CMD_PULSE
    |=> convert_out ##1 !convert_out)
    else $error("convert pulse not one cycle");
  reset_cmd_a: assert property (take && q.st == ST_CMD
    && cmd_code == CMD_RESET
    |=> dev_reset_out && q.regs == REG_RESET)
    else $error("reset command did not restore defaults");
  burst_adv_a: assert property (take && q.burst
    && (q.st == ST_RREG || q.st == ST_WREG) && q.addr < ADDR_ID
    |=> q.addr == $past(q.addr) + 4'h1 && q.st == $past(q.st))
    else $error("burst address did not advance");
  single_end_a: assert property (take && !q.burst
    && (q.st == ST_RREG || q.st == ST_WREG) |=> q.st == ST_CMD)
    else $error("single access did not end");
  id_stop_a: assert property (take && q.addr == ADDR_ID
    && (q.st == ST_RREG || q.st == ST_WREG) |=> q.st == ST_CMD)
    else $error("burst ran past identifier");
  cs_abort_a: assert property (q.cs_s2 |=> q.st == ST_CMD)
    else $error("select high did not abort");
  tmo_fire_a: assert property (tmo_fire
    |=> q.link_rst && q.st == ST_CMD ##1 !q.link_rst)
    else $error("timeout did not reset link");
  tmo_short_a: assert property (q.regs[ADDR_CFG_A][A_TMO_BIT]
    && $past(q.regs[ADDR_CFG_A][A_TMO_BIT])
    |-> q.tmo <= TMO_SHORT_LAST)
    else $error("short timeout exceeded");
  rsv_zero_a: assert property (!q.regs[ADDR_CFG_A][A_RSV_HI]
    && !q.regs[ADDR_CFG_A][A_RSV_LO])
    else $error("reserved config bits set");
  clk_pin_a: assert property (q.csel_s2
    |=> !clock_out_enable_out)
    else $error("clock output enabled with external clock");
  fixed_mask_a: assert property (q.regs[ADDR_CFG_A][A_SCAN_BIT]
    |=> monitor_scan_out == 8'h00 && single_scan_out == 16'h0000
    && fixed_input_out == $past(q.regs[ADDR_FIXED]))
    else $error("scan selections leak in fixed mode");

  direct_read_c: cover property (q.st == ST_DIRECT
    && q.idx == LAST_DATA_IDX);
  burst_id_c: cover property (take && q.burst && q.addr == ADDR_ID);
  timeout_c: cover property (tmo_fire);
  write_c: cover property (take && q.st == ST_WREG);
endmodule

// >>> rtl/adc_cmd_pkg.sv
// constants shared by the serial command decoder and its link shifter
// assumes an 8-bit register bank behind a byte-wide serial link
package adc_cmd_pkg;
  // register addresses
  localparam logic [3:0] ADDR_CFG_A = 4'h0;
  localparam logic [3:0] ADDR_CFG_B = 4'h1;
  localparam logic [3:0] ADDR_FIXED = 4'h2;
  localparam logic [3:0] ADDR_DIFF = 4'h3;
  localparam logic [3:0] ADDR_SG_LO = 4'h4;
  localparam logic [3:0] ADDR_SG_HI = 4'h5;
  localparam logic [3:0] ADDR_MON = 4'h6;
  localparam logic [3:0] ADDR_PDIR = 4'h7;
  localparam logic [3:0] ADDR_PVAL = 4'h8;
  localparam logic [3:0] ADDR_ID = 4'h9;
  // reset values and writable masks, index 8 down to 0
  localparam logic [8:0][7:0] REG_RESET = {8'h00, 8'hff, 8'h00, 8'hff,
    8'hff, 8'h00, 8'h00, 8'h83, 8'h0a};
  localparam logic [8:0][7:0] REG_WMASK = {8'hff, 8'hff, 8'h3d, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h7e};
  // value is arbitrary
  localparam logic [7:0] PART_ID_VALUE = 8'h5a;
  // command byte layout and codes
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 5;
  localparam int BURST_BIT = 4;
  localparam int ADDR_MSB = 3;
  localparam int ADDR_LSB = 0;
  localparam logic [2:0] CMD_DIRECT_A = 3'h0;
  localparam logic [2:0] CMD_FRAMED = 3'h1;
  localparam logic [2:0] CMD_RREG = 3'h2;
  localparam logic [2:0] CMD_WREG = 3'h3;
  localparam logic [2:0] CMD_PULSE = 3'h4;
  localparam logic [2:0] CMD_RSVD = 3'h5;
  localparam logic [2:0] CMD_RESET = 3'h6;
  localparam logic [2:0] CMD_DIRECT_B = 3'h7;
  // config a fields
  localparam int A_RSV_HI = 7;
  localparam int A_TMO_BIT = 6;
  localparam int A_SCAN_BIT = 5;
  localparam int A_EXT_BIT = 4;
  localparam int A_CLKEN_BIT = 3;
  localparam int A_CHOP_BIT = 2;
  localparam int A_STAT_BIT = 1;
  localparam int A_RSV_LO = 0;
  // config b fields
  localparam int B_IDLE_BIT = 7;
  localparam int B_DLY_MSB = 6;
  localparam int B_DLY_LSB = 4;
  localparam int B_BIAS_MSB = 3;
  localparam int B_BIAS_LSB = 2;
  localparam int B_RATE_MSB = 1;
  localparam int B_RATE_LSB = 0;
  localparam int DLY_W = 3;
  localparam int BIAS_W = 2;
  localparam int RATE_W = 2;
  // serial inactivity timeout in master clocks
  localparam int TMO_LONG_CYC = 4096;
  localparam int TMO_SHORT_CYC = 256;
  localparam logic [11:0] TMO_LONG_LAST = 12'(TMO_LONG_CYC - 1);
  localparam logic [11:0] TMO_SHORT_LAST = 12'(TMO_SHORT_CYC - 1);
  // byte framing
  localparam logic [2:0] BYTE_FIRST_BIT = 3'h0;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [1:0] LAST_DATA_IDX = 2'h3;
  localparam logic [1:0] HOLD_CYC = 2'h3;
  typedef enum logic [2:0] {ST_CMD, ST_DIRECT, ST_FRAMED, ST_RREG,
    ST_WREG} cmd_state_t;
endpackage

// >>> rtl/adc_serial_link.sv
// byte shifter on the serial link clock
// assumes clock idle low, data launched on rising, sampled on falling
`timescale 1ns/100ps
module adc_serial_link (
  // link clock and frame reset
  input wire logic sclk_in,
  input wire logic link_rst_in,
  // serial data
  input wire logic mosi_in,
  output logic miso_out,
  // core side
  input wire logic [7:0] tx_byte_in,
  output logic [7:0] rx_byte_out,
  output logic rx_toggle_out
);
  import adc_cmd_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
    logic [7:0] rx;
    logic tgl;
  } rx_state_t;
  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
    logic bit_out;
  } tx_state_t;

  rx_state_t rq;
  rx_state_t rd;
  tx_state_t tq;
  tx_state_t td;

  //////////////////////////////////////////////////////////////////////
  // rx byte completes on falling edge 8; tx byte loads on rising edge 1
  always_comb
  begin
    rd = rq;
    rd.cnt = rq.cnt + 3'h1;
    if (rq.cnt == BYTE_LAST_BIT)
    begin
      rd.rx = {rq.sh, mosi_in};
      rd.tgl = !rq.tgl; // event to the core, held stable for a byte
    end
    else
    begin
      rd.sh = {rq.sh[5:0], mosi_in};
    end
    td = tq;
    td.cnt = tq.cnt + 3'h1;
    if (tq.cnt == BYTE_FIRST_BIT)
    begin
      td.bit_out = tx_byte_in[7];
      td.sh = tx_byte_in[6:0];
    end
    else
    begin
      td.bit_out = tq.sh[6];
      td.sh = {tq.sh[5:0], 1'b0};
    end
  end

  // the link clock stops outside frames, so the frame signal resets it
  always_ff @(negedge sclk_in or posedge link_rst_in)
  begin
    if (link_rst_in)
      rq <= '0;
    else
      rq <= rd;
  end

  always_ff @(posedge sclk_in or posedge link_rst_in)
  begin
    if (link_rst_in)
      tq <= '0;
    else
      tq <= td;
  end

  assign miso_out = tq.bit_out;
  assign rx_byte_out = rq.rx;
  assign rx_toggle_out = rq.tgl;
endmodule

// >>> dv/spi_host_model.sv
// host side model: spi master, clock idle low, cpol0 cpha1, msb first
// assumes the device samples on falling edges and launches on rising
`timescale 1ns/100ps
module spi_host_model (
  // link pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  // half period of the 80 ns link clock
  localparam int HALF = 40;
  // clock stands low and select high outside frames
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // 120 ns from select low to the first rising edge
  task automatic open_frame();
    cs_n_out = 1'b0;
    #120;
  endtask
  // select high ends every access; released data shows the inverse
  task automatic close_frame();
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #200;
  endtask
  // one byte; the gap gives the device time to load its reply
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk_out = 1'b1;
      mosi_out = tx[i];
      #HALF;
      sclk_out = 1'b0;
      rx[i] = miso_in;
      #HALF;
    end
    #120;
  endtask
endmodule

// >>> dv/adc_serial_cmd_tb_top.sv
// self-checking bench of the serial command decoder
// assumes the host model drives the link; converter side is static apart from the clock source pin
`timescale 1ns/100ps
module adc_serial_cmd_tb_top;
  import adc_cmd_pkg::*;
  typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] r;} row_t;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic clk_src = 1'b0;
  logic sclk, cs_n, mosi, miso, conv_p, rst_p;
  logic tmo_sel, scan_sel, ext_sel, clk_en, chop, low_pwr;
  logic [2:0] dly;
  logic [1:0] bias, rate;
  logic [7:0] fixed, diff, mon, pdir, pval;
  logic [15:0] single;
  logic [95:0] rx_v;
  int miscompares = 0;
  int n_compared = 0;
  int n_conv = 0;
  int n_rst = 0;
  // port value reads give the pins, not the latch
  row_t rows [8] = '{'{4'h1, 8'h55, 8'h55}, '{4'h2, 8'h12, 8'h12},
    '{4'h3, 8'ha5, 8'ha5}, '{4'h4, 8'h0f, 8'h0f}, '{4'h5, 8'hf0, 8'hf0},
    '{4'h6, 8'h2d, 8'h2d}, '{4'h7, 8'h0f, 8'h0f}, '{4'h8, 8'h81, 8'h3c}};
  logic [7:0] dflt [10] = '{8'h0a, 8'h83, 8'h00, 8'h00, 8'hff, 8'hff,
    8'h00, 8'hff, 8'h3c, PART_ID_VALUE};
  ////////////////////////////////////////////////////////////////////////
  // master clock, 10 ns
  always #5 mclk_in = ~mclk_in;
  // pulse counters; a stuck pulse counts many times
  always @(posedge mclk_in)
  begin
    if (conv_p === 1'b1) n_conv++;
    if (rst_p === 1'b1) n_rst++;
  end
  adc_serial_cmd u_adc_serial_cmd (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso),
    .status_in(8'ha5), .conv_data_in(24'h123456),
    .clock_source_pin_in(clk_src), .port_pins_in(8'h3c),
    .convert_out(conv_p), .dev_reset_out(rst_p),
    .serial_timeout_select_out(tmo_sel), .scan_or_single_select_out(scan_sel),
    .external_path_select_out(ext_sel), .clock_out_enable_out(clk_en),
    .chop_enable_out(chop), .low_power_select_out(low_pwr),
    .settle_delay_out(dly), .sensor_bias_level_out(bias),
    .conversion_rate_select_out(rate), .fixed_input_out(fixed),
    .diff_scan_out(diff), .single_scan_out(single), .monitor_scan_out(mon),
    .port_direction_out(pdir), .port_value_out(pval));
  spi_host_model u_spi_host_model (.sclk_out(sclk), .cs_n_out(cs_n),
    .mosi_out(mosi), .miso_in(miso));
  ////////////////////////////////////////////////////////////////////////
  // helpers; inputs move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [95:0] tx, input int n);
    logic [7:0] b;
    u_spi_host_model.open_frame();
    for (int i = 0; i < n; i++)
    begin
      u_spi_host_model.xfer(tx[95-8*i -: 8], b);
      rx_v[95-8*i -: 8] = b;
    end
    u_spi_host_model.close_frame();
    cyc(10);
  endtask
  // burst read from 2 with an idle gap; last reply tells timeout or not
  task automatic pause_read(input logic [7:0] exp);
    logic [7:0] b;
    u_spi_host_model.open_frame();
    u_spi_host_model.xfer(8'h52, b);
    u_spi_host_model.xfer(8'h00, b);
    cyc(300);
    u_spi_host_model.xfer(8'h41, b);
    u_spi_host_model.xfer(8'h00, b);
    u_spi_host_model.close_frame();
    chk(40'(b), 40'(exp));
  endtask
  function automatic logic [39:0] cfgv();
    return 40'({tmo_sel, scan_sel, ext_sel, clk_en, chop, low_pwr, dly,
      bias, rate});
  endfunction
  task automatic conclude();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog, well above the expected 82 us run
  initial
  begin
    #500_000;
    miscompares++;
    conclude();
  end
  // main sequence
  initial
  begin
    cyc(12);
    rstn_in = 1'b1;
    cyc(10);
    chk(cfgv(), 40'h283);
    frame({8'h50, 80'h0, 8'h9f}, 12);
    for (int i = 0; i < 10; i++)
      chk(40'(rx_v[87-8*i -: 8]), 40'(dflt[i]));
    chk(40'(n_conv), 40'd1);
    foreach (rows[i])
    begin
      frame({4'h6, rows[i].a, rows[i].w, 80'h0}, 2);
      frame({4'h4, rows[i].a, 88'h0}, 2);
      chk(40'(rx_v[87 -: 8]), 40'(rows[i].r));
    end
    chk(cfgv(), 40'h255);
    chk({fixed, diff, single, mon}, 40'h00a5f00f2d);
    chk(40'({pdir, pval}), 40'h0f81);
    frame({8'h00, 88'h0}, 4);
    chk(40'(rx_v[95 -: 32]), 40'ha5123456);
    // reserved bits written as zero
    frame({8'h60, 8'h72, 80'h0}, 2);
    frame({8'h40, 88'h0}, 2);
    chk(40'(rx_v[87 -: 8]), 40'h72);
    chk(cfgv(), 40'h1c55);
    chk({fixed, diff, single, mon}, 40'h1200000000);
    frame({8'he0, 88'h0}, 4);
    chk(40'(rx_v[95 -: 32]), 40'h12345600);
    frame({8'h30, 88'h0}, 5);
    chk(40'(rx_v[87 -: 32]), 40'ha5123456);
    // burst write cut short by select high
    frame({8'h73, 8'h11, 8'h22, 72'h0}, 3);
    frame({8'h44, 88'h0}, 2);
    chk(40'(rx_v[87 -: 8]), 40'h22);
    // the next command byte must not have landed in register 5
    frame({8'h45, 88'h0}, 2);
    chk(40'(rx_v[87 -: 8]), 40'hf0);
    pause_read(8'h55);
    frame({8'h60, 8'h32, 80'h0}, 2);
    pause_read(8'h22);
    frame({8'ha0, 8'h9f, 80'h0}, 2);
    chk(40'(n_conv), 40'd2);
    chk(40'(n_rst), 40'd0);
    frame({8'hdf, 88'h0}, 1);
    chk(40'(n_rst), 40'd1);
    chk(cfgv(), 40'h283);
    clk_src = 1'b1;
    cyc(6);
    chk(40'(clk_en), 40'h0);
    // chop set with no internal reading, then a mid-run reset
    frame({8'h60, 8'h04, 80'h0}, 2);
    chk(40'(chop), 40'h1);
    rstn_in = 1'b0;
    cyc(2);
    rstn_in = 1'b1;
    cyc(1);
    chk(40'(clk_en), 40'h0);
    cyc(1);
    chk(cfgv(), 40'h083);
    conclude();
  end
endmodule
